// *** shared/vo_pkg.sv ***
// Constants shared by the video output control block.
package vo_pkg;
  // ==========================================================
  // Register offsets on the plain register port.
  localparam logic [7:0] OUT_CTL_ADDR  = 8'h03;
  localparam logic [7:0] EXT_CTL_ADDR  = 8'h04;
  localparam logic [7:0] GPO_CTL_ADDR  = 8'h05;
  localparam logic [7:0] STATUS_ADDR   = 8'h06;
  // ==========================================================
  // Reset values.
  localparam logic [7:0] OUT_CTL_RST   = 8'h00;
  localparam logic [7:0] EXT_CTL_RST   = 8'h0c;
  localparam logic [7:0] GPO_CTL_RST   = 8'h00;
  // ==========================================================
  // Field positions.
  localparam int STYLE_LSB   = 0;
  localparam int FMT_LSB     = 2;
  localparam int FLOAT_BIT   = 6;
  localparam int PASS_BIT    = 7;
  localparam int RANGE_BIT   = 0;
  localparam int EXTSEL_LSB  = 4;
  localparam int REV_BIT     = 7;
  localparam int LOW_DRV_BIT  = 4;
  localparam int HIGH_DRV_BIT = 5;
  localparam int CBLANK_BIT  = 6;
  localparam int LOCKR_BIT   = 7;
  // ==========================================================
  // Field codes.
  localparam logic [1:0] STYLE_BAD     = 2'h3;
  localparam logic [3:0] FMT_10_FULL   = 4'h0;
  localparam logic [3:0] FMT_20_HALF   = 4'h1;
  localparam logic [3:0] FMT_16_HALF   = 4'h2;
  localparam logic [3:0] FMT_8_FULL    = 4'h3;
  localparam logic [3:0] FMT_12_HALF   = 4'h4;
  // ==========================================================
  // Sample limits and datapath sizes.
  localparam logic [9:0] CCIR_LO       = 10'h040;
  localparam logic [9:0] CCIR_HI       = 10'h3c0;
  localparam logic [9:0] CHROMA_ZERO   = 10'h200;
  localparam int         FIFO_DEPTH    = 8;
  localparam int         WORD_W        = 21;
endpackage

// *** hdl/vo_top.sv ***
// Video output control registers, pixel FIFO and output formatter.
//
// Function
// R1 - Two-bit timing style; code three is invalid.
// R2 - Codes 0000/0011: 10/8-bit 4:2:2, full-rate clock.
// R3 - Code 0001: 20-bit 4:2:2 at half rate.
// R4 - 0010 16-bit, 0100 12-bit 4:1:1, rest unused.
// R5 - Float bit forces drivers off; else follow pin. The code gates only the pixel pins; extra and general outputs ignore both.
// R6 - Passthrough bit: blanking lines get minimal filtering.
// R7 - Range bit: CCIR limits or full range.
// R8 - Chroma blank bit zeroes colour during blanking.
// R9 - Lock routing puts lock flag on output 0.
// R10 - Extra select zero leaves twelve extra pins floating.
// R11 - Revision bit picks BT656-3 or BT656-4 framing.
// R12 - General outputs driven only where format provides.
// R13 - Low/high drive enables gate output pairs.
// R14 - Software keeps reserved extended bits at 110.
`timescale 1ns/1ps

// ==========================================================
// Parameterised FIFO with valid and ready on both sides.
module vo_fifo #(
  parameter int W = 21,
  parameter int D = 8
) (
  // Clock and reset.
  input  wire logic           i_core_clk,
  input  wire logic           i_arst_n,
  // Fill side.
  input  wire logic           i_in_valid,
  output logic                o_in_ready,
  input  wire logic [W-1:0]   i_in_data,
  // Drain side.
  output logic                o_out_valid,
  input  wire logic           i_out_ready,
  output logic [W-1:0]        o_out_data,
  // Fill level.
  output logic [$clog2(D):0]  o_level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Handshake terms and honest flags.
  assign o_in_ready  = (cnt_q != (AW+1)'(D));
  assign o_out_valid = (cnt_q != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rp_q];
  assign o_level     = cnt_q;

  // Storage array, written only on a push.
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wp_q] <= i_in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= push ? wp_q + 1'b1 : wp_q;
      rp_q  <= pop ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==========================================================
// Top: register bank and pixel output path.
module vo_top (
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  // Register port.
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  output logic [7:0]       o_rd_data,
  // Decoded pixel stream from the decoder core.
  input  wire logic        i_pix_valid,
  output logic             o_pix_ready,
  input  wire logic [9:0]  i_pix_luma,
  input  wire logic [9:0]  i_pix_chroma,
  input  wire logic        i_pix_blank_line,
  input  wire logic        i_hlock,
  // Output enable pin, active low.
  input  wire logic        i_oe_n,
  // Pixel port.
  output logic [19:0]      o_pix_data,
  output logic [19:0]      o_pix_oe_n,
  output logic             o_pix_strobe,
  output logic             o_line_locked_clock_half,
  // Extra pins and general outputs.
  output logic [11:0]      o_extra_data,
  output logic [11:0]      o_extra_oe_n,
  output logic [3:0]       o_general_outputs,
  output logic [3:0]       o_general_outputs_oe_n,
  // Mode levels toward the framing logic.
  output logic [1:0]       o_output_timing_style,
  output logic             o_bt656_rev4,
  output logic             o_blanking_interval_passthrough
);
  logic [7:0]  out_ctl_q;
  logic [7:0]  ext_ctl_q;
  logic [7:0]  gpo_ctl_q;
  logic [7:0]  rd_q;
  logic [2:0]  oe_sync_q;
  logic        oe_n_q;
  logic        fifo_valid;
  logic [20:0] fifo_data;
  logic [3:0]  fifo_level;
  logic        pop;
  logic [20:0] word_q;
  logic        have_q;
  logic        phase_q;
  logic [19:0] pix_q;
  logic        strobe_q;
  logic [3:0]  gpo_q;
  logic [11:0] extra_q;

  // Clamp a sample to a window.
  function automatic logic [9:0] clip(input logic [9:0] v, input logic [9:0] lo,
                                      input logic [9:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ========================================================
  // Register fields.
  wire [1:0] style    = out_ctl_q[vo_pkg::STYLE_LSB +: 2];
  wire [3:0] fmt      = out_ctl_q[vo_pkg::FMT_LSB +: 4];
  wire       force_driver_float = out_ctl_q[vo_pkg::FLOAT_BIT];
  wire       blanking_pass      = out_ctl_q[vo_pkg::PASS_BIT];
  wire       full_range         = ext_ctl_q[vo_pkg::RANGE_BIT];
  wire [2:0] extra_pin_data_select = ext_ctl_q[vo_pkg::EXTSEL_LSB +: 3];
  wire       low_outputs_drive_enable  = gpo_ctl_q[vo_pkg::LOW_DRV_BIT];
  wire       high_outputs_drive_enable = gpo_ctl_q[vo_pkg::HIGH_DRV_BIT];
  wire       chroma_blank_in_blanking  = gpo_ctl_q[vo_pkg::CBLANK_BIT];
  wire       lock_flag_routing         = gpo_ctl_q[vo_pkg::LOCKR_BIT];

  // Format decode.
  wire fmt_full  = (fmt == vo_pkg::FMT_10_FULL) || (fmt == vo_pkg::FMT_8_FULL);
  wire fmt_half  = (fmt == vo_pkg::FMT_20_HALF) || (fmt == vo_pkg::FMT_16_HALF) ||
                   (fmt == vo_pkg::FMT_12_HALF);
  wire fmt_valid = fmt_full || fmt_half; // R4
  wire gpo_avail = fmt_full; // R12

  // Register port decode; a style write of code three is dropped.
  wire wr_out   = i_wr_stb && (i_addr == vo_pkg::OUT_CTL_ADDR);
  wire wr_ext   = i_wr_stb && (i_addr == vo_pkg::EXT_CTL_ADDR);
  wire wr_gpo   = i_wr_stb && (i_addr == vo_pkg::GPO_CTL_ADDR);
  wire [1:0] style_d = (i_wr_data[1:0] == vo_pkg::STYLE_BAD) ? style
                                                              : i_wr_data[1:0]; // R1
  wire [7:0] status  = {3'h0, fifo_level, oe_n_q};
  wire [7:0] rd_mux  = (i_addr == vo_pkg::OUT_CTL_ADDR) ? out_ctl_q :
                       (i_addr == vo_pkg::EXT_CTL_ADDR) ? ext_ctl_q :
                       (i_addr == vo_pkg::GPO_CTL_ADDR) ? gpo_ctl_q :
                       (i_addr == vo_pkg::STATUS_ADDR)  ? status : 8'h00;

  // Control registers and registered read data.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_ctl_q <= vo_pkg::OUT_CTL_RST;
      ext_ctl_q <= vo_pkg::EXT_CTL_RST; // R14
      gpo_ctl_q <= vo_pkg::GPO_CTL_RST;
      rd_q      <= 8'h00;
    end else begin
      if (wr_out) begin
        out_ctl_q <= {i_wr_data[7:2], style_d};
      end
      if (wr_ext) begin
        ext_ctl_q <= i_wr_data;
      end
      if (wr_gpo) begin
        gpo_ctl_q <= i_wr_data;
      end
      rd_q <= i_rd_stb ? rd_mux : 8'h00;
    end
  end

  // Output enable pin: three stages, a change counts when the last two agree.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oe_sync_q <= 3'h7;
      oe_n_q    <= 1'b1;
    end else begin
      oe_sync_q <= {oe_sync_q[1:0], i_oe_n};
      oe_n_q    <= (oe_sync_q[1] == oe_sync_q[2]) ? oe_sync_q[2] : oe_n_q;
    end
  end

  // ========================================================
  // Pixel FIFO; a full FIFO stalls the decoder core.
  vo_fifo #(
    .W (vo_pkg::WORD_W),
    .D (vo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (i_pix_valid),
    .o_in_ready  (o_pix_ready),
    .i_in_data   ({i_pix_blank_line, i_pix_chroma, i_pix_luma}),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_data),
    .o_level     (fifo_level)
  );

  // Each word is held two cycles: chroma then luma, or both at half rate.
  assign pop = fifo_valid && (!have_q || phase_q);

  // Sample processing: range limiting, skipped on blanking lines in passthrough.
  wire       w_vbi   = word_q[20];
  wire       bypass  = full_range || (blanking_pass && w_vbi); // R6 R7
  wire [9:0] luma    = bypass ? word_q[9:0]
                              : clip(word_q[9:0], vo_pkg::CCIR_LO, vo_pkg::CCIR_HI);
  wire [9:0] chroma_c = bypass ? word_q[19:10]
                               : clip(word_q[19:10], vo_pkg::CCIR_LO, vo_pkg::CCIR_HI);
  wire [9:0] chroma  = (chroma_blank_in_blanking && w_vbi) ? vo_pkg::CHROMA_ZERO
                                                            : chroma_c; // R8
  wire [9:0] comp    = phase_q ? luma : chroma;

  // Output word by format.
  wire [19:0] pix_d = (fmt == vo_pkg::FMT_10_FULL) ? {10'h000, comp} :             // R2
                      (fmt == vo_pkg::FMT_8_FULL)  ? {12'h000, comp[9:2]} :        // R2
                      (fmt == vo_pkg::FMT_20_HALF) ? {luma, chroma} :              // R3
                      (fmt == vo_pkg::FMT_16_HALF) ? {4'h0, luma[9:2], chroma[9:2]} : // R4
                      (fmt == vo_pkg::FMT_12_HALF) ? {8'h00, luma[9:2], chroma[9:6]} :
                      20'h00000;

  // Output stage.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      word_q   <= '0;
      have_q   <= 1'b0;
      phase_q  <= 1'b0;
      pix_q    <= '0;
      strobe_q <= 1'b0;
      gpo_q    <= '0;
      extra_q  <= '0;
    end else begin
      word_q   <= pop ? fifo_data : word_q;
      have_q   <= pop || (have_q && !phase_q);
      phase_q  <= pop ? 1'b0 : (have_q && !phase_q);
      pix_q    <= pix_d;
      strobe_q <= have_q && fmt_valid && (fmt_full || !phase_q);
      gpo_q    <= {gpo_ctl_q[3:1], lock_flag_routing ? i_hlock : gpo_ctl_q[0]}; // R9
      extra_q  <= (extra_pin_data_select == 3'h0) ? 12'h000 : {chroma, 2'h0};
    end
  end

  // ========================================================
  // Pin drivers; enables are low while driving.
  wire pix_drive = !force_driver_float && !oe_n_q && fmt_valid; // R5
  assign o_pix_oe_n = {20{!pix_drive}};
  assign o_extra_oe_n = {12{extra_pin_data_select == 3'h0}}; // R10
  assign o_general_outputs_oe_n = {{2{!(gpo_avail && high_outputs_drive_enable)}},
                                   {2{!(gpo_avail && low_outputs_drive_enable)}}}; // R12 R13
  assign o_pix_data = pix_q;
  assign o_pix_strobe = strobe_q;
  assign o_line_locked_clock_half = phase_q;
  assign o_extra_data = extra_q;
  assign o_general_outputs = gpo_q;
  assign o_rd_data = rd_q;
  assign o_output_timing_style = style; // R1
  assign o_bt656_rev4 = ext_ctl_q[vo_pkg::REV_BIT]; // R11
  assign o_blanking_interval_passthrough = blanking_pass; // R6

  // ========================================================
  // Checks.
  sequence s_bad_style;
    wr_out && (i_wr_data[1:0] == vo_pkg::STYLE_BAD);
  endsequence
  property p_style;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      s_bad_style |=> (style == $past(style));
  endproperty
  a_style: assert property (p_style) else $error("Invalid style was stored."); // R1

  property p_narrow;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (fmt == vo_pkg::FMT_8_FULL) && $stable(fmt) |=> (o_pix_data[19:8] == 12'h000);
  endproperty
  a_narrow: assert property (p_narrow) else $error("8-bit format used high bits."); // R2

  property p_wide;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (fmt == vo_pkg::FMT_20_HALF) && have_q && !full_range && !blanking_pass
        |=> (o_pix_data[19:10] >= vo_pkg::CCIR_LO);
  endproperty
  a_wide: assert property (p_wide) else $error("Luma below limit in 20-bit mode."); // R3 R7

  property p_unused;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      !fmt_valid |-> (&o_pix_oe_n) && (&o_general_outputs_oe_n);
  endproperty
  a_unused: assert property (p_unused) else $error("Unused format drives pins."); // R4 R12

  property p_float;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      force_driver_float || oe_n_q |-> (&o_pix_oe_n);
  endproperty
  a_float: assert property (p_float) else $error("Pixel drivers on while floated."); // R5

  property p_blank;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (fmt == vo_pkg::FMT_20_HALF) && w_vbi && chroma_blank_in_blanking
        |=> (o_pix_data[9:0] == vo_pkg::CHROMA_ZERO);
  endproperty
  a_blank: assert property (p_blank) else $error("Chroma not blanked."); // R8

  property p_lock;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      lock_flag_routing |=> (o_general_outputs[0] == $past(i_hlock));
  endproperty
  a_lock: assert property (p_lock) else $error("Lock flag not routed."); // R9

  property p_extra;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (extra_pin_data_select == 3'h0) |-> (&o_extra_oe_n);
  endproperty
  a_extra: assert property (p_extra) else $error("Extra pins driven."); // R10

  property p_pair;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      !low_outputs_drive_enable |-> (&o_general_outputs_oe_n[1:0]);
  endproperty
  a_pair: assert property (p_pair) else $error("Low outputs driven."); // R13

  sequence s_rd_ext;
    i_rd_stb && (i_addr == vo_pkg::EXT_CTL_ADDR) && !i_wr_stb;
  endsequence
  property p_rev;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      s_rd_ext |=> (o_rd_data[7] == o_bt656_rev4);
  endproperty
  a_rev: assert property (p_rev) else $error("Revision bit mismatch."); // R11
endmodule

// *** test/vo_sink.sv ***
// Downstream video processor model that captures strobed pixel words.
`timescale 1ns/1ps

// ==========================================================
// Capture model of the receiver on the pixel port.
module vo_sink (
  // Clock and reset.
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  // Pixel port as seen on the pins.
  input  wire logic [19:0]  i_pix_data,
  input  wire logic [19:0]  i_pix_oe_n,
  input  wire logic         i_pix_strobe,
  // Captured words and number of strobes seen.
  output logic [19:0]       o_last_word,
  output logic [19:0]       o_prev_word,
  output logic [15:0]       o_word_count
);
  logic [19:0] bus_q;
  logic [19:0] bus_w;

  // A released pin shows the inverse of its last level, so stale data never matches.
  assign bus_w = (i_pix_data & ~i_pix_oe_n) | (~bus_q & i_pix_oe_n);

  // Each strobed cycle hands over one new word; the one before it is kept too.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_q        <= 20'h00000;
      o_last_word  <= 20'h00000;
      o_prev_word  <= 20'h00000;
      o_word_count <= 16'h0000;
    end else begin
      bus_q <= bus_w;
      if (i_pix_strobe) begin
        o_prev_word  <= o_last_word;
        o_last_word  <= bus_w;
        o_word_count <= o_word_count + 16'h0001;
      end
    end
  end
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the video output control block.
`timescale 1ns/1ps

// ==========================================================
// Bench top: register and pixel tasks, then the scenario sequence.
module tb_top;
  // Design inputs, all defined from time zero.
  logic        i_core_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [7:0]  i_wr_data = 8'h00;
  logic        i_wr_stb = 1'b0;
  logic        i_rd_stb = 1'b0;
  logic        i_pix_valid = 1'b0;
  logic [9:0]  i_pix_luma = 10'h000;
  logic [9:0]  i_pix_chroma = 10'h000;
  logic        i_pix_blank_line = 1'b0;
  logic        i_hlock = 1'b0;
  logic        i_oe_n = 1'b0;
  // Design outputs and capture results.
  logic [7:0]  o_rd_data;
  logic        o_pix_ready, o_pix_strobe, o_bt656_rev4, o_blanking_interval_passthrough;
  logic [19:0] o_pix_data, o_pix_oe_n, last, prev;
  logic [11:0] o_extra_oe_n, o_extra_data;
  logic        o_line_locked_clock_half, h0;
  logic [3:0]  o_general_outputs, o_general_outputs_oe_n;
  logic [1:0]  o_output_timing_style;
  logic [15:0] cnt, c0;
  int          err_total = 0;
  int          n_compared = 0;
  int          n;
  // Pixel sample pair and expectations for format codes 0 to 5.
  localparam logic [9:0] LU = 10'h2a4;
  localparam logic [9:0] CH = 10'h1b8;
  logic [19:0] el [6] = '{20'(LU), {LU, CH}, {4'h0, LU[9:2], CH[9:2]}, 20'(LU[9:2]),
                          {8'h00, LU[9:2], CH[9:6]}, 20'h0};
  logic [19:0] mk [6] = '{20'h003ff, 20'hfffff, 20'h0ffff, 20'h000ff, 20'h00fff, 20'h0};
  logic [19:0] pm [6] = '{20'h003ff, 20'h0, 20'h0, 20'h000ff, 20'h0, 20'h0};
  logic [19:0] ep [6] = '{20'(CH), 20'h0, 20'h0, 20'(CH[9:2]), 20'h0, 20'h0};
  logic [15:0] nd [6] = '{16'h2, 16'h1, 16'h1, 16'h2, 16'h1, 16'h0};

  // Clock at 40 MHz.
  always #12.5 i_core_clk = ~i_core_clk;

  // Design under test and the downstream receiver.
  vo_top vo_top_inst (.i_core_clk, .i_arst_n, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb,
    .o_rd_data, .i_pix_valid, .o_pix_ready, .i_pix_luma, .i_pix_chroma, .i_pix_blank_line,
    .i_hlock, .i_oe_n, .o_pix_data, .o_pix_oe_n, .o_pix_strobe, .o_line_locked_clock_half,
    .o_extra_data, .o_extra_oe_n, .o_general_outputs, .o_general_outputs_oe_n,
    .o_output_timing_style, .o_bt656_rev4, .o_blanking_interval_passthrough);
  vo_sink vo_sink_inst (.i_core_clk, .i_arst_n, .i_pix_data(o_pix_data),
    .i_pix_oe_n(o_pix_oe_n), .i_pix_strobe(o_pix_strobe), .o_last_word(last),
    .o_prev_word(prev), .o_word_count(cnt));

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Lets k edges pass and lands just after the last one.
  task automatic step(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_core_clk);
    i_wr_stb <= 1'b0;
    #1;
  endtask

  // One-cycle register read, data taken in the cycle after the strobe.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_core_clk);
    i_rd_stb <= 1'b0;
    #1;
    chk(20'(o_rd_data), 20'(exp));
  endtask

  // Offers one pixel word and holds it until the edge that takes it.
  task automatic px(input logic [9:0] l, input logic [9:0] c, input logic b);
    i_pix_valid <= 1'b1;
    i_pix_luma <= l;
    i_pix_chroma <= c;
    i_pix_blank_line <= b;
    #1;
    for (n = 0; n < 50 && o_pix_ready !== 1'b1; n++) step(1);
    if (n == 50) begin
      err_total++;
      conclude();
    end
    @(posedge i_core_clk);
    i_pix_valid <= 1'b0;
    #1;
  endtask

  // Main scenario sequence.
  initial begin
    step(10);
    i_arst_n <= 1'b1;
    step(1);
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h0c);
    rdchk(8'h05, 8'h00);
    wr(8'h20, 8'hff);
    rdchk(8'h20, 8'h00);
    wr(8'h06, 8'hff);
    rdchk(8'h06, 8'h00);
    for (int s = 0; s < 3; s++) begin
      wr(8'h03, {6'h00, 2'(s)});
      chk(20'(o_output_timing_style), 20'(s));
    end
    wr(8'h03, 8'h07);
    rdchk(8'h03, 8'h06);
    wr(8'h04, 8'h8c);
    chk(20'(o_bt656_rev4), 20'h1);
    rdchk(8'h04, 8'h8c);
    wr(8'h04, 8'h0c);
    chk(20'(o_bt656_rev4), 20'h0);
    chk(20'(o_extra_oe_n), 20'hfff);
    wr(8'h03, 8'h00);
    step(2);
    chk(o_pix_oe_n & 20'h003ff, 20'h0);
    wr(8'h03, 8'h40);
    step(2);
    chk(o_pix_oe_n, 20'hfffff);
    wr(8'h03, 8'h00);
    i_oe_n <= 1'b1;
    step(6);
    chk(o_pix_oe_n, 20'hfffff);
    i_oe_n <= 1'b0;
    step(6);
    for (int k = 0; k < 6; k++) begin
      wr(8'h03, {2'b00, 4'(k), 2'b00});
      c0 = cnt;
      px(LU, CH, 1'b0);
      step(12);
      chk(20'(cnt - c0), 20'(nd[k]));
      chk(last & mk[k], el[k]);
      chk(prev & pm[k], ep[k]);
    end
    chk(o_pix_oe_n, 20'hfffff);
    wr(8'h03, 8'h00);
    for (int r = 0; r < 2; r++) begin
      wr(8'h04, {7'h06, 1'(r)});
      px(10'h3f0, 10'h010, 1'b0);
      step(12);
      chk(last & 20'h003ff, r ? 20'h003f0 : 20'h003c0);
      chk(prev & 20'h003ff, r ? 20'h00010 : 20'h00040);
    end
    wr(8'h04, 8'h0c);
    wr(8'h03, 8'h80);
    chk(20'(o_blanking_interval_passthrough), 20'h1);
    px(10'h3f0, 10'h010, 1'b1);
    step(12);
    chk(last & 20'h003ff, 20'h003f0);
    wr(8'h03, 8'h04);
    wr(8'h05, 8'h40);
    px(LU, CH, 1'b1);
    step(12);
    chk(last, {LU, 10'h200});
    px(LU, CH, 1'b0);
    step(12);
    chk(last, {LU, CH});
    wr(8'h05, 8'h3a);
    step(2);
    chk(20'(o_general_outputs_oe_n), 20'hf);
    wr(8'h03, 8'h00);
    step(2);
    chk(20'(o_general_outputs), 20'ha);
    chk(20'(o_general_outputs_oe_n), 20'h0);
    wr(8'h05, 8'h1a);
    step(2);
    chk(20'(o_general_outputs_oe_n), 20'hc);
    wr(8'h05, 8'h2a);
    step(2);
    chk(20'(o_general_outputs_oe_n), 20'h3);
    wr(8'h05, 8'h90);
    i_hlock <= 1'b1;
    step(3);
    chk(20'(o_general_outputs[0]), 20'h1);
    wr(8'h05, 8'h10);
    step(3);
    chk(20'(o_general_outputs[0]), 20'h0);
    wr(8'h04, 8'h1c);
    step(2);
    chk(20'(o_extra_oe_n), 20'h000);
    chk(20'(o_extra_data), 20'({CH, 2'h0}));
    i_pix_valid <= 1'b1;
    for (n = 0; n < 40 && o_pix_ready === 1'b1; n++) step(1);
    chk(20'(o_pix_ready), 20'h0);
    h0 = o_line_locked_clock_half;
    step(1);
    chk(20'(o_line_locked_clock_half ^ h0), 20'h1);
    i_pix_valid <= 1'b0;
    step(30);
    chk(20'(o_pix_ready), 20'h1);
    rdchk(8'h06, 8'h00);
    conclude();
  end
endmodule
